/* File: hdl/sar_consts.svh */
// Purpose: shared numbers for the converter link and its two ends
// Assumes: host clock of 50 MHz, 20 ns period
// Notes:   times are kept in ns; cycle counts are derived from them
`ifndef SAR_CONSTS_SVH
`define SAR_CONSTS_SVH

// frame layout
`define SAR_FRAME_BITS      16
`define SAR_RESULT_BITS     12
`define SAR_LEAD_ZEROS      4

// falling-edge counts that steer the device
`define SAR_EDGE_GLITCH     2
`define SAR_EDGE_KEEP_ON    10
`define SAR_EDGE_RETRACK    13
`define SAR_EDGE_LAST       16

// host clock and link timing
`define SAR_MCLK_NS         20
`define SAR_QUIET_NS        100
`define SAR_ACQ_NS          275
`define SAR_PWRUP_NS        1000
`define SAR_QUIET_CYC       ((`SAR_QUIET_NS + `SAR_MCLK_NS - 1) / `SAR_MCLK_NS)
`define SAR_ACQ_CYC         ((`SAR_ACQ_NS + `SAR_MCLK_NS - 1) / `SAR_MCLK_NS)
`define SAR_PWRUP_CYC       ((`SAR_PWRUP_NS + `SAR_MCLK_NS - 1) / `SAR_MCLK_NS)

// half period of the generated serial clock, in host clocks
`define SAR_HALF_CYC        3

`endif

/* File: hdl/sar_pkg.sv */
// Purpose: types shared by the converter link ends
// Assumes: nothing beyond the constants header
// Notes:   numbers live in sar_consts.svh
package sar_pkg;

  // host sequencer states
  typedef enum logic [1:0]
  {
    h_idle  = 2'b00,
    h_frame = 2'b01,
    h_gap   = 2'b10
  } host_state_t;

endpackage : sar_pkg

/* File: hdl/sar_link_if.sv */
// Purpose: the serial link between the converter and its host
// Assumes: the host makes the serial clock and the frame select
// Notes:   the data line is resolved here; an undriven line reads high
`timescale 1ns/1ps

interface sar_link_if;
  logic sclk;               // serial clock, made by the host, idles low
  logic cs_n;               // frame select, active low
  logic serial_result_out;  // data bit driven by the device
  logic serial_result_out_oe;           // high while the device drives the data line
  logic serial_result_out_line;         // resolved level of the data line

  // weak pull-up stands for the released line
  assign serial_result_out_line = serial_result_out_oe ? serial_result_out : 1'b1;

  modport dev
  (
    input  sclk,
    input  cs_n,
    output serial_result_out,
    output serial_result_out_oe
  );

  modport host
  (
    output sclk,
    output cs_n,
    input  serial_result_out_line
  );
endinterface : sar_link_if

/* File: hdl/adc_dev.sv */
// Purpose: conversion and serial readout control of the converter end
// Assumes: clocked only by the link clock and the frame select edges;
//          the host gives no serial clock edge while frame select is high
// Notes:   resetn_i is synchronous to whichever link edge clocks a flop
`timescale 1ns/1ps
`include "sar_consts.svh"

////////////////////////////////////////////////////////////////////////
module adc_dev
(
  input  wire logic                          resetn_i,        // synchronous, active low
  input  wire logic [`SAR_RESULT_BITS-1:0]   sample_value_i,  // value the analog front end settles to
  output logic                               powered_o,       // analog circuitry fully powered
  output logic                               tracking_o,      // sample-hold is tracking
  output logic                               busy_o,          // a conversion frame is running
  output logic                               aborted_o,       // last frame ended early
  sar_link_if.dev                            link             // serial link to the host
);

  ////////////////////////////////////////////////////////////////////
  // declarations
  localparam logic [4:0] EDGE_GLITCH  = 5'(`SAR_EDGE_GLITCH);
  localparam logic [4:0] EDGE_KEEP_ON = 5'(`SAR_EDGE_KEEP_ON);
  localparam logic [4:0] EDGE_RETRACK = 5'(`SAR_EDGE_RETRACK);
  localparam logic [4:0] EDGE_LAST    = 5'(`SAR_EDGE_LAST);

  logic                          start_tag;   // flips on every frame select fall
  logic                          seen_tag;    // copy of start_tag taken by the serial clock
  logic [4:0]                    fall_cnt;    // serial clock falls seen in the current frame
  logic [4:0]                    eff_cnt;     // fall count as seen by the current frame
  logic [`SAR_RESULT_BITS-1:0]   held;        // sampled result
  logic [`SAR_FRAME_BITS-1:0]    frame_word;  // whole output frame
  logic [3:0]                    bit_idx;     // index of the bit on the line
  logic                          rt_set;      // sample-hold returned to track
  logic                          rt_tag;      // frame in which rt_set was raised
  logic                          rt_valid;    // rt_set belongs to the current frame
  logic                          powered;     // power mode register
  logic                          waking;      // a wake-up frame is running
  logic                          aborted;     // last frame ended before sixteen falls

  ////////////////////////////////////////////////////////////////////
  // frame start: sample the input and mark a new frame
  // the frame select fall is the only event that opens a frame
  always_ff @(negedge link.cs_n)
  begin
    if (!resetn_i)
    begin
      start_tag <= 1'b0;
    end
    else
    begin
      start_tag <= ~start_tag;
    end
  end

  // the held value is caught at the hold instant
  always_ff @(negedge link.cs_n)
  begin
    if (!resetn_i)
    begin
      held <= '0;
    end
    else
    begin
      held <= sample_value_i;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // falling edge counter, run by the serial clock itself
  // the first fall of a new frame restarts the count at one; no
  // clear from frame select is needed, so the count stays stable
  // while frame select rises and the power decision reads it
  always_ff @(negedge link.sclk)
  begin
    if (!resetn_i)
    begin
      seen_tag <= 1'b0;
      fall_cnt <= 5'h00;
    end
    else if (seen_tag != start_tag)
    begin
      // first fall of a fresh frame
      seen_tag <= start_tag;
      fall_cnt <= 5'h01;
    end
    else if (fall_cnt < EDGE_LAST)
    begin
      // one more falling edge, saturating at the end of the frame
      fall_cnt <= fall_cnt + 5'h01;
    end
  end

  // before the first fall of a frame the count reads as zero
  assign eff_cnt = (seen_tag == start_tag) ? fall_cnt : 5'h00;

  ////////////////////////////////////////////////////////////////////
  // output frame and data line
  assign frame_word = {{`SAR_LEAD_ZEROS{1'b0}}, held};

  // bit 15 of the frame leaves at the select fall, bit 15-k after fall k
  assign bit_idx = 4'(`SAR_FRAME_BITS - 1) - eff_cnt[3:0];

  // the line is driven only while select is low and fewer than
  // sixteen falls have passed; a rise of select releases at once
  assign link.serial_result_out_oe = ~link.cs_n & (eff_cnt < EDGE_LAST);

  // the fifteenth fall puts the last bit out; it stands to the 16th
  assign link.serial_result_out = frame_word[bit_idx];

  ////////////////////////////////////////////////////////////////////
  // sample-hold return to tracking
  // raised on the first rising edge after the thirteenth fall and
  // tagged with its frame so that a later frame sees it as stale
  always_ff @(posedge link.sclk)
  begin
    if (!resetn_i)
    begin
      rt_set <= 1'b0;
      rt_tag <= 1'b0;
    end
    else if (eff_cnt >= EDGE_RETRACK)
    begin
      rt_set <= 1'b1;
      rt_tag <= start_tag;
    end
    else
    begin
      // any earlier rise drops a retrack left over from an older frame
      rt_set <= 1'b0;
    end
  end

  // a retrack counts only once this frame has passed its thirteenth fall
  assign rt_valid = rt_set & (rt_tag == start_tag) & (eff_cnt >= EDGE_RETRACK);

  ////////////////////////////////////////////////////////////////////
  // power mode, decided at the frame select rise
  // fewer than two falls: no change, glitches are ignored;
  // two to nine falls: power down; ten or more: stay or become powered
  always_ff @(posedge link.cs_n)
  begin
    if (!resetn_i)
    begin
      powered <= 1'b1;
    end
    else if (eff_cnt >= EDGE_KEEP_ON)
    begin
      powered <= 1'b1;
    end
    else if (eff_cnt >= EDGE_GLITCH)
    begin
      powered <= 1'b0;
    end
    else
    begin
      // a glitch keeps normal mode; from power-down it stays down
      powered <= powered;
    end
  end

  // abort flag, also taken at the frame select rise
  always_ff @(posedge link.cs_n)
  begin
    if (!resetn_i)
    begin
      aborted <= 1'b0;
    end
    else
    begin
      aborted <= (eff_cnt < EDGE_LAST);
    end
  end

  // a frame started from power-down is a wake-up frame
  always_ff @(negedge link.cs_n)
  begin
    if (!resetn_i)
    begin
      waking <= 1'b0;
    end
    else
    begin
      waking <= ~powered;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // user-side status
  // a wake-up frame powers the analog part only from the tenth fall on
  assign powered_o  = powered | (waking & ~link.cs_n & (eff_cnt >= EDGE_KEEP_ON));

  // tracking while powered and idle, or once retracked within a frame;
  // a wake-up frame returns to track at its first serial clock fall
  assign tracking_o = (powered & link.cs_n) | rt_valid
                    | (waking & ~link.cs_n & (eff_cnt != 5'h00));

  // busy while a frame is being clocked out
  assign busy_o     = ~link.cs_n & (eff_cnt < EDGE_LAST);

  // early end of the last frame
  assign aborted_o  = aborted;

endmodule : adc_dev

/* File: hdl/adc_host.sv */
// Purpose: serial master that runs conversion frames on the converter
// Assumes: mclk_i at 50 MHz; serial clock made by dividing it
// Notes:   len_i below 16 gives an aborted or power-down frame
`timescale 1ns/1ps
`include "sar_consts.svh"

module adc_host
#(
  parameter int  HALF_CYC     = `SAR_HALF_CYC,  // serial clock half period, host clocks
  parameter bit  CAPTURE_RISE = 1'b0            // capture bits on rising edges
)
(
  input  wire logic                         mclk_i,          // host clock
  input  wire logic                         resetn_i,        // synchronous, active low
  input  wire logic                         start_i,         // request a frame
  input  wire logic [4:0]                   len_i,           // falls to give, 1..16
  output logic                              ready_o,         // a request is taken now
  output logic [`SAR_RESULT_BITS-1:0]       result_o,        // last whole result
  output logic                              result_valid_o,  // one-cycle pulse with result_o
  output logic                              asleep_o,        // converter left powered down
  sar_link_if.host                          link             // serial link to the converter
);

  ////////////////////////////////////////////////////////////////////
  // declarations
  localparam logic [6:0] QUIET_CYC = 7'(`SAR_QUIET_CYC);
  localparam logic [6:0] ACQ_CYC   = 7'(`SAR_ACQ_CYC);
  localparam logic [6:0] PWRUP_CYC = 7'(`SAR_PWRUP_CYC);
  localparam logic [3:0] HALF      = 4'(HALF_CYC);

  sar_pkg::host_state_t            state;     // sequencer state
  logic [3:0]                      ph;        // host clocks within a half period
  logic                            sclk_q;    // generated serial clock
  logic                            cs_q;      // generated frame select
  logic [4:0]                      falls;     // falls given in this frame
  logic [4:0]                      len_q;     // falls asked for
  logic [6:0]                      gap;       // host clocks left before the next frame
  logic [1:0]                      sync;      // two-flop synchroniser of the data line
  logic [`SAR_FRAME_BITS-1:0]      shreg;     // received frame bits
  logic                            wake;      // this frame is a dummy wake-up
  logic                            edge_now;  // end of a half period
  logic                            cap_now;   // capture edge of the chosen polarity

  assign link.sclk = sclk_q;
  assign link.cs_n = cs_q;
  assign asleep_o  = wake;
  assign ready_o   = (state == sarh_idle_ok());

  function automatic sar_pkg::host_state_t sarh_idle_ok();
    sarh_idle_ok = sar_pkg::h_idle;
  endfunction : sarh_idle_ok

  assign edge_now = (ph == HALF - 4'h1);
  assign cap_now  = edge_now & (CAPTURE_RISE ? ~sclk_q : sclk_q);

  ////////////////////////////////////////////////////////////////////
  // data line synchroniser
  always_ff @(posedge mclk_i)
  begin
    if (!resetn_i)
    begin
      sync <= 2'b11;
    end
    else
    begin
      sync <= {sync[0], link.serial_result_out_line};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // sequencer: idle, frame, then a gap honouring quiet and acquisition
  always_ff @(posedge mclk_i)
  begin
    if (!resetn_i)
    begin
      state  <= sar_pkg::h_idle;
      ph     <= 4'h0;
      sclk_q <= 1'b0;
      cs_q   <= 1'b1;
      falls  <= 5'h00;
      len_q  <= 5'h10;
      gap    <= 7'h00;
    end
    else
    begin
      unique case (state)
        sar_pkg::h_idle:
        begin
          if (start_i)
          begin
            // a new conversion always begins with a select fall
            cs_q  <= 1'b0;
            len_q <= (len_i == 5'h00) ? 5'h01
                   : (len_i > 5'h10)  ? 5'h10 : len_i;
            falls <= 5'h00;
            ph    <= 4'h0;
            state <= sar_pkg::h_frame;
          end
        end
        sar_pkg::h_frame:
        begin
          ph <= edge_now ? 4'h0 : ph + 4'h1;
          if (edge_now)
          begin
            if (falls == len_q)
            begin
              // all asked falls given: raise select, start the gap
              cs_q  <= 1'b1;
              gap   <= (len_q < 5'(`SAR_EDGE_KEEP_ON)) ? QUIET_CYC
                     : (wake ? PWRUP_CYC : ACQ_CYC);
              state <= sar_pkg::h_gap;
            end
            else
            begin
              sclk_q <= ~sclk_q;
              if (sclk_q)
              begin
                falls <= falls + 5'h01;
              end
            end
          end
        end
        sar_pkg::h_gap:
        begin
          gap <= gap - 7'h01;
          if (gap <= 7'h01)
          begin
            state <= sar_pkg::h_idle;
          end
        end
        default:
        begin
          state <= sar_pkg::h_idle;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // receive shift register and result
  always_ff @(posedge mclk_i)
  begin
    if (!resetn_i)
    begin
      shreg          <= '0;
      result_o       <= '0;
      result_valid_o <= 1'b0;
    end
    else
    begin
      result_valid_o <= 1'b0;
      if ((state == sar_pkg::h_frame) && cap_now && (falls < 5'h10))
      begin
        shreg <= {shreg[`SAR_FRAME_BITS-2:0], sync[1]};
      end
      if ((state == sar_pkg::h_frame) && edge_now && (falls == len_q)
          && (len_q == 5'h10) && !wake)
      begin
        result_o       <= shreg[`SAR_RESULT_BITS-1:0];
        result_valid_o <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // power state of the converter as the host believes it
  always_ff @(posedge mclk_i)
  begin
    if (!resetn_i)
    begin
      wake <= 1'b1;
    end
    else if ((state == sar_pkg::h_frame) && edge_now && (falls == len_q))
    begin
      if (len_q >= 5'(`SAR_EDGE_KEEP_ON))
      begin
        wake <= 1'b0;
      end
      else if (len_q >= 5'(`SAR_EDGE_GLITCH))
      begin
        wake <= 1'b1;
      end
    end
  end

endmodule : adc_host

/* File: test/sar_link_properties.sv */
// Purpose: watches the serial link between the converter and its host
// Assumes: link signals are sampled on the host clock
// Notes:   falls counts serial clock falls of the running frame
`timescale 1ns/1ps
`include "sar_consts.svh"

module sar_link_properties
(
  input  wire logic mclk_i,             // host clock
  input  wire logic resetn_i,           // active low, converter reset only
  input  wire logic sclk,               // serial clock
  input  wire logic cs_n,               // frame select, active low
  input  wire logic serial_result_out,  // device data bit
  input  wire logic serial_result_out_oe,           // device drives the data line
  input  wire logic serial_result_out_line          // resolved data line
);
  logic       sclk_q;    // serial clock one host clock ago
  logic [4:0] fall_cnt;  // falls before this sample
  logic [4:0] falls;     // falls up to this sample

  assign falls = fall_cnt + {4'h0, sclk_q & ~sclk};

  ////////////////////////////////////////////////////////////////////////
  // count serial clock falls, cleared while select is high
  always_ff @(posedge mclk_i)
  begin
    sclk_q <= sclk;
    if (!resetn_i || cs_n)
      fall_cnt <= 5'h00;
    else
      fall_cnt <= falls;
  end

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);

  ////////////////////////////////////////////////////////////////////////
  idle_release_a: assert property (cs_n |-> !serial_result_out_oe)
    else $error("data line driven while select high");
  select_drive_a: assert property ($fell(cs_n) |-> serial_result_out_oe && !serial_result_out)
    else $error("no leading zero at select fall");
  frame_drive_a: assert property (!cs_n && falls < 5'h10 |-> serial_result_out_oe)
    else $error("data line released inside frame");
  last_release_a: assert property (!cs_n && falls == 5'h10 |-> !serial_result_out_oe)
    else $error("data line held after last fall");
  lead_zero_a: assert property (!cs_n && falls < 5'h04 |-> !serial_result_out_line)
    else $error("leading bit not zero");
  bit_hold_a: assert property (!cs_n && serial_result_out_oe && !$fell(sclk) && !$fell(cs_n)
    |-> $stable(serial_result_out))
    else $error("data bit changed off a falling edge");
  frame_count_a: assert property (!cs_n |-> falls <= 5'h10)
    else $error("more than sixteen falls in a frame");
  quiet_gap_a: assert property ($rose(cs_n) |-> cs_n [*5])
    else $error("select fell inside quiet time");
  sclk_idle_a: assert property (cs_n |-> !sclk)
    else $error("serial clock high outside frame");
  half_period_a: assert property ($rose(sclk) |-> sclk [*3] ##1 !sclk)
    else $error("serial clock half period wrong");

  full_frame_c: cover property ($rose(cs_n) && fall_cnt == 5'h10);
  sleep_frame_c: cover property ($rose(cs_n) && fall_cnt >= 5'h02 && fall_cnt < 5'h0a);
  abort_frame_c: cover property ($rose(cs_n) && fall_cnt >= 5'h0a && fall_cnt < 5'h10);
endmodule : sar_link_properties

/* File: test/sar_adc_serial_readout_bench.sv */
// Purpose: runs host and converter ends against each other
// Assumes: default serial clock divider of the host
// Notes:   first frame runs with the converter held in reset
`timescale 1ns/1ps
`include "sar_consts.svh"

module sar_adc_serial_readout_bench;
  logic        mclk_i;           // host clock
  logic        resetn_i;         // host reset, active low
  logic        dev_resetn;       // converter reset, active low
  logic        start_i;          // frame request
  logic [4:0]  len_i;            // falls per frame
  logic        ready_o;          // host idle
  logic [11:0] result_o;         // last result
  logic        result_valid_o;   // result pulse
  logic        asleep_o;         // host view of power-down
  logic [11:0] sample_value;     // analog value model
  logic        powered_o;        // converter powered
  logic        tracking_o;       // sample-hold tracking
  logic        aborted_o;        // frame ended early
  int          n_mismatch = 0;   // mismatches
  int          samples_checked = 0; // comparisons
  int          nfall = 0;        // serial clock falls this frame
  int          frames = 0;       // select falls seen
  int          n_req = 0;        // frames requested
  int          cycles = 0;       // host clocks run
  logic        busy;             // converter frame running
  logic [11:0] result_rise;      // result of the rising-edge host
  logic        valid_rise;       // result pulse of the rising-edge host
  logic        pow_was = 1'b1;   // expected power state
  logic [4:0]  corner [16] = '{5'h10, 5'h10, 5'h01, 5'h10, 5'h02, 5'h10, 5'h09, 5'h10,
                               5'h10, 5'h0a, 5'h10, 5'h0f, 5'h0b, 5'h03, 5'h10, 5'h10};

  sar_link_if sar_link_if_inst ();

  adc_host adc_host_inst
  (
    .mclk_i         (mclk_i),
    .resetn_i       (resetn_i),
    .start_i        (start_i),
    .len_i          (len_i),
    .ready_o        (ready_o),
    .result_o       (result_o),
    .result_valid_o (result_valid_o),
    .asleep_o       (asleep_o),
    .link           (sar_link_if_inst.host)
  );

  adc_dev adc_dev_inst
  (
    .resetn_i       (dev_resetn),
    .sample_value_i (sample_value),
    .powered_o      (powered_o),
    .tracking_o     (tracking_o),
    .busy_o         (busy),
    .aborted_o      (aborted_o),
    .link           (sar_link_if_inst.dev)
  );

  sar_link_properties sar_link_properties_inst
  (
    .mclk_i            (mclk_i),
    .resetn_i          (dev_resetn),
    .sclk              (sar_link_if_inst.sclk),
    .cs_n              (sar_link_if_inst.cs_n),
    .serial_result_out (sar_link_if_inst.serial_result_out),
    .serial_result_out_oe          (sar_link_if_inst.serial_result_out_oe),
    .serial_result_out_line        (sar_link_if_inst.serial_result_out_line)
  );

  // second pair: host capturing on rising edges, same requests
  sar_link_if sar_link_if_rise_inst ();

  adc_host
  #(
    .CAPTURE_RISE (1'b1)
  )
  adc_host_rise_inst
  (
    .mclk_i         (mclk_i),
    .resetn_i       (resetn_i),
    .start_i        (start_i),
    .len_i          (len_i),
    .ready_o        (),
    .result_o       (result_rise),
    .result_valid_o (valid_rise),
    .asleep_o       (),
    .link           (sar_link_if_rise_inst.host)
  );

  adc_dev adc_dev_rise_inst
  (
    .resetn_i       (dev_resetn),
    .sample_value_i (sample_value),
    .powered_o      (),
    .tracking_o     (),
    .busy_o         (),
    .aborted_o      (),
    .link           (sar_link_if_rise_inst.dev)
  );

  ////////////////////////////////////////////////////////////////////////
  // clock, edge counters and hang guard
  initial
  begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  always @(negedge sar_link_if_inst.sclk) nfall++;
  always @(negedge sar_link_if_inst.cs_n) frames++;
  always @(posedge mclk_i)
  begin
    cycles++;
    if (cycles == 32'h4e20)
    begin
      n_mismatch++;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power state after a frame of len falls
  function automatic logic exp_power(input logic [4:0] len, input logic was);
    if (len < 5'h02)
      return was;
    return len >= 5'h0a;
  endfunction : exp_power

  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////////////////
  // one frame: request, watch, then judge the outcome
  task automatic run_frame(input logic [4:0] len, input bit judge);
    int   t;
    logic full;
    t = 0;
    full = (len == 5'h10) && pow_was;
    while (ready_o !== 1'b1 && t < 300)
    begin
      @(posedge mclk_i);
      #2;
      t++;
    end
    if (t == 300)
      n_mismatch++;
    sample_value = 12'($urandom);
    len_i = len;
    start_i = 1'b1;
    nfall = 0;
    n_req++;
    @(posedge mclk_i);
    #2;
    t = 0;
    while (sar_link_if_inst.cs_n !== 1'b1 && t < 300)
    begin
      start_i = (nfall == 5);  // mid-frame request must be dropped
      if (judge && nfall == 12) check("busy_o", busy, 1'b1);
      if (judge && pow_was && nfall == 12) check("tracking_o", tracking_o, 1'b0);
      if (judge && pow_was && len > 5'h0d && nfall == 13 && sar_link_if_inst.sclk)
        check("tracking_o", tracking_o, 1'b1);
      @(posedge mclk_i);
      #2;
      t++;
    end
    if (t == 300)
      n_mismatch++;
    if (judge)
    begin
      check("result_valid_o", result_valid_o, full);
      if (full) check("result_o", result_o, sample_value);
      check("result_valid_o rise", valid_rise, full);
      if (full) check("result_o rise", result_rise, sample_value);
      check("busy_o", busy, 1'b0);
      check("powered_o", powered_o, exp_power(len, pow_was));
      check("aborted_o", aborted_o, len < 5'h10);
      check("frames", frames[11:0], n_req[11:0]);
      if (len == 5'h10 || (len > 5'h01 && len < 5'h0a))
        check("asleep_o", asleep_o, !exp_power(len, pow_was));
    end
    pow_was = exp_power(len, pow_was);
  endtask : run_frame

  ////////////////////////////////////////////////////////////////////////
  // main sequence: reset frame, corner lengths, random lengths
  initial
  begin
    resetn_i = 1'b0;
    dev_resetn = 1'b0;
    start_i = 1'b0;
    len_i = 5'h10;
    sample_value = 12'h000;
    void'($urandom(32'hf77c));
    repeat (4) @(posedge mclk_i);
    #2;
    resetn_i = 1'b1;
    run_frame(5'h10, 1'b0);
    dev_resetn = 1'b1;
    foreach (corner[i])
      run_frame(corner[i], 1'b1);
    repeat (40)
      run_frame(($urandom % 2) ? 5'h10 : 5'($urandom_range(32'hf, 32'h1)), 1'b1);
    conclude();
  end
endmodule : sar_adc_serial_readout_bench
